// ===== hw/zdc_pkg.sv
// package: register offsets, field positions, widths and opcodes for the zoom/decimation control block
package zdc_pkg;
  localparam logic [5:0] OFF_COUNT_LOW    = 6'h28;
  localparam logic [5:0] OFF_COUNT_BYTE1  = 6'h2a;
  localparam logic [5:0] OFF_COUNT_BYTE2  = 6'h2c;
  localparam logic [5:0] OFF_COUNT_TOP    = 6'h2e;
  localparam logic [5:0] OFF_COARSE_HIGH  = 6'h30;
  localparam logic [5:0] OFF_COARSE_LOW   = 6'h32;
  localparam logic [5:0] OFF_FINE_BYTE3   = 6'h34;
  localparam logic [5:0] OFF_FINE_BYTE2   = 6'h36;
  localparam logic [5:0] OFF_FINE_BYTE1   = 6'h38;
  localparam logic [5:0] OFF_FINE_BYTE0   = 6'h3a;
  localparam logic [5:0] OFF_CONV_CTRL    = 6'h26;
  localparam logic [5:0] OFF_ZOOM_CTRL    = 6'h3c;
  localparam logic [5:0] OFF_LO_XFER      = 6'h3e;
  localparam int COUNT_W      = 25;
  localparam int COARSE_W     = 11;
  localparam int FINE_W       = 29;
  localparam int ACC_W        = COARSE_W + FINE_W;
  localparam int STAGE_W      = 5;
  localparam int MODE_LSB     = 5;
  localparam int SHIFT_LSB    = 8;
  localparam int ALT_BIT      = 10;
  localparam int COARSE_LO_LSB = 5;
  localparam int FINE_LO_LSB  = 3;
  localparam int OPC_W        = 4;
  localparam logic [2:0] MODE_RESET      = 3'h0;
  localparam logic [2:0] MODE_CALIBRATED = 3'h7;
  localparam logic [4:0] STAGE_MAX       = 5'h18;
  localparam logic [OPC_W-1:0] OPC_NOP   = 4'h0;
  localparam logic [2:0] MODE_RST_VAL    = 3'h0;
  localparam logic [4:0] STAGE_RST_VAL   = 5'h00;
endpackage

// ===== hw/zdc_strobe.sv
// module: one-cycle pulse on the rising edge of a bus-side request level
module zdc_strobe
  import zdc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic req,
  output logic      pulse
);
  logic req_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      req_q <= 1'b0;
      pulse <= 1'b0;
    end else begin
      req_q <= req;
      pulse <= req & ~req_q;
    end
  end
endmodule

// ===== hw/zdc_top.sv
// module: zoom/decimation control, staging registers and frequency shifter
//
// Notes on behaviour
// - 3-bit converter mode; 0 resets, 1 uncalibrated, 2-6 partial corrections, 7 calibrated.
// - 25-bit captured count read as bytes at 28H, 2AH, 2CH, 2EH bit 0.
// - bits 9-8 of read word at 28H give the trigger shift value.
// - bit 10 of read word at 28H gives the alternate count flag.
// - captured count, shift and alternate flag hold after a trigger.
// - stage select is low five bits written at 28H; 0 bypasses decimation.
// - stage N in 1..24 sets trigger bandwidth to rate over 2^(N+1).
// - any write to 2AH clears all decimation filter state.
// - filter clear leaves the decimation pattern counter unchanged.
// - any write to 2CH copies decimation counter into captured count.
// - each sample is multiplied by cosine plus j sine of the phase.
// - every sample adds working frequency to working phase, except in a cycle where a recall strobe (opcodes 2-7) wins.
// - working phase and frequency are only reached through staging registers.
// - coarse staging is 11 bits in two bytes; upper access byte ignored.
// - low three coarse bits sit in bits 7:5 at 32H; others read zero.
// - fine staging is 29 bits over 34H..3AH; upper access byte ignored.
// - low three bits at 3AH read zero and are ignored on writes.
// - staging registers store from or recall into working registers.
// - 4-bit opcode selects transfer; 0 does nothing.
// - a transfer strobe write acts on the next clock cycle.
module zdc_top
  import zdc_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic [5:0]          bus_addr,
  input  wire logic [15:0]         bus_wdata,
  input  wire logic                bus_wr,
  input  wire logic                bus_rd,
  output logic      [15:0]         bus_rdata,
  input  wire logic                sample_valid,
  input  wire logic signed [15:0]  sample_in,
  input  wire logic                trigger_event,
  input  wire logic [1:0]          trigger_shift_in,
  output logic      [2:0]          converter_mode_select,
  output logic                     converter_reset,
  output logic      [4:0]          stage_select,
  output logic                     decimation_bypass,
  output logic      [4:0]          trigger_bw_exponent,
  output logic                     filter_clear,
  output logic      [COUNT_W-1:0]  decim_counter,
  output logic                     shifted_valid,
  output logic signed [15:0]       shifted_re,
  output logic signed [15:0]       shifted_im
);
  logic [COUNT_W-1:0] captured_decimation_count;
  logic [1:0]         trigger_shift;
  logic               alternate_count_flag;
  logic [COARSE_W-1:0] coarse_stage;
  logic [FINE_W-1:0]   fine_stage;
  logic [ACC_W-1:0]    work_freq;
  logic [ACC_W-1:0]    work_phase;
  logic [OPC_W-1:0]    xfer_opcode;
  logic clear_req, capture_req, xfer_req;
  logic clear_pulse, capture_pulse;
  logic trig_q;
  logic trig_rise;
  logic wr_hit_clear, wr_hit_capture, wr_hit_xfer;

  // write strobe levels, high as long as the write lasts; clear and capture are turned to clean pulses below
  assign wr_hit_clear   = bus_wr && bus_addr == OFF_COUNT_BYTE1;
  assign wr_hit_capture = bus_wr && bus_addr == OFF_COUNT_BYTE2;
  assign wr_hit_xfer    = bus_wr && bus_addr == OFF_LO_XFER;
  assign clear_req      = wr_hit_clear;
  assign capture_req    = wr_hit_capture;
  assign xfer_req       = wr_hit_xfer;
  assign trig_rise      = trigger_event & ~trig_q;

  zdc_strobe u_clear (
    .clk_sys (clk_sys),
    .rst     (rst),
    .req     (clear_req),
    .pulse   (clear_pulse)
  );

  zdc_strobe u_capture (
    .clk_sys (clk_sys),
    .rst     (rst),
    .req     (capture_req),
    .pulse   (capture_pulse)
  );

  // converter mode, stage select and zoom opcode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      converter_mode_select <= MODE_RST_VAL;
      converter_reset       <= 1'b1;
      stage_select          <= STAGE_RST_VAL;
      decimation_bypass     <= 1'b1;
      trigger_bw_exponent   <= 5'h01;
      xfer_opcode           <= OPC_NOP;
    end else begin
      if (bus_wr && bus_addr == OFF_CONV_CTRL) begin
        converter_mode_select <= bus_wdata[MODE_LSB +: 3];
        converter_reset       <= bus_wdata[MODE_LSB +: 3] == MODE_RESET;
      end
      if (bus_wr && bus_addr == OFF_COUNT_LOW) begin
        stage_select        <= bus_wdata[STAGE_W-1:0];
        decimation_bypass   <= bus_wdata[STAGE_W-1:0] == 5'h00;
        // exponent N+1; values above 24 are not defined, so they are just passed on
        trigger_bw_exponent <= bus_wdata[STAGE_W-1:0] + 5'h01;
      end
      if (bus_wr && bus_addr == OFF_ZOOM_CTRL)
        xfer_opcode <= bus_wdata[OPC_W-1:0];
    end
  end

  // filter clear pulse goes out; the pattern counter is left alone by it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      filter_clear <= 1'b0;
    else
      filter_clear <= clear_pulse;
  end

  // decimation pattern counter, advanced per sample only while decimation is not bypassed
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      decim_counter <= '0;
    else if (sample_valid && !decimation_bypass)
      decim_counter <= decim_counter + 25'h0000001;
  end

  // count and flag captured on software strobe or trigger, shift on trigger only, held otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trig_q                    <= 1'b0;
      captured_decimation_count <= '0;
      trigger_shift             <= 2'h0;
      alternate_count_flag      <= 1'b0;
    end else begin
      trig_q <= trigger_event;
      if (capture_pulse || trig_rise) begin
        captured_decimation_count <= decim_counter;
        alternate_count_flag      <= decim_counter[0];
      end
      if (trig_rise)
        trigger_shift <= trigger_shift_in;
    end
  end

  // staging registers: bus writes, or store from working registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      coarse_stage <= '0;
      fine_stage   <= '0;
    end else if (xfer_req && xfer_opcode != OPC_NOP &&
                 (xfer_opcode == 4'h1 || xfer_opcode[3])) begin
      if (xfer_opcode == 4'h1) begin
        coarse_stage <= work_freq[ACC_W-1 -: COARSE_W];
        fine_stage   <= work_phase[FINE_W-1:0];
      end else begin
        if (xfer_opcode != 4'h9 && xfer_opcode != 4'hc && xfer_opcode != 4'hd)
          coarse_stage <= (xfer_opcode == 4'hb || xfer_opcode == 4'hf) ?
                          work_phase[ACC_W-1 -: COARSE_W] : work_freq[ACC_W-1 -: COARSE_W];
        // opcodes 8, 10 and 11 store the coarse part only, so the fine stage keeps its value
        if (xfer_opcode != 4'h8 && xfer_opcode != 4'ha && xfer_opcode != 4'hb)
          fine_stage <= (xfer_opcode == 4'hd || xfer_opcode == 4'hf || xfer_opcode == 4'h9) ?
                        work_phase[FINE_W-1:0] : work_freq[FINE_W-1:0];
      end
    end else if (bus_wr) begin
      unique case (bus_addr)
        OFF_COARSE_HIGH: coarse_stage[COARSE_W-1:3] <= bus_wdata[7:0];
        OFF_COARSE_LOW:  coarse_stage[2:0] <= bus_wdata[7:COARSE_LO_LSB];
        OFF_FINE_BYTE3:  fine_stage[28:21] <= bus_wdata[7:0];
        OFF_FINE_BYTE2:  fine_stage[20:13] <= bus_wdata[7:0];
        OFF_FINE_BYTE1:  fine_stage[12:5]  <= bus_wdata[7:0];
        OFF_FINE_BYTE0:  fine_stage[4:0]   <= bus_wdata[7:FINE_LO_LSB];
        default: ;
      endcase
    end
  end

  // working registers: recall on strobe (acts the cycle after the write), else accumulate
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      work_freq  <= '0;
      work_phase <= '0;
    end else begin
      if (xfer_req && xfer_opcode >= 4'h2 && xfer_opcode <= 4'h7) begin
        unique case (xfer_opcode)
          4'h2: work_freq[ACC_W-1 -: COARSE_W]  <= coarse_stage;
          4'h3: work_phase[ACC_W-1 -: COARSE_W] <= coarse_stage;
          4'h4: work_freq[FINE_W-1:0]           <= fine_stage;
          4'h5: work_phase[FINE_W-1:0]          <= fine_stage;
          4'h6: work_freq                       <= {coarse_stage, fine_stage};
          default: work_phase                   <= {coarse_stage, fine_stage};
        endcase
      end else if (sample_valid) begin
        work_phase <= work_phase + work_freq;
      end
    end
  end

  // quarter-wave cosine/sine from top phase bits, kept coarse to save area
  function automatic logic signed [15:0] zdc_cos(input logic [7:0] ph);
    logic [5:0]  idx;
    logic signed [15:0] mag;
    idx = ph[5:0];
    mag = 16'sh7fff - $signed({1'b0, idx, 9'h000}) / 16'sh0040 * idx;
    unique case (ph[7:6])
      2'b00: zdc_cos = mag;
      2'b01: zdc_cos = -$signed({1'b0, idx, 9'h000});
      2'b10: zdc_cos = -mag;
      default: zdc_cos = $signed({1'b0, idx, 9'h000});
    endcase
  endfunction

  function automatic logic signed [15:0] zdc_mul(input logic signed [15:0] a, input logic signed [15:0] b);
    logic signed [31:0] p;
    p = a * b;
    zdc_mul = p[30:15];
  endfunction

  // complex mixer output registered
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shifted_valid <= 1'b0;
      shifted_re    <= '0;
      shifted_im    <= '0;
    end else begin
      shifted_valid <= sample_valid;
      if (sample_valid) begin
        shifted_re <= zdc_mul(sample_in, zdc_cos(work_phase[ACC_W-1 -: 8]));
        shifted_im <= zdc_mul(sample_in, zdc_cos(work_phase[ACC_W-1 -: 8] - 8'h40));
      end
    end
  end

  // read port; working registers have no address of their own
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      bus_rdata <= 16'h0000;
    else if (bus_rd) begin
      unique case (bus_addr)
        OFF_COUNT_LOW:   bus_rdata <= {5'h00, alternate_count_flag, trigger_shift,
                                       captured_decimation_count[7:0]};
        OFF_COUNT_BYTE1: bus_rdata <= {8'h00, captured_decimation_count[15:8]};
        OFF_COUNT_BYTE2: bus_rdata <= {8'h00, captured_decimation_count[23:16]};
        OFF_COUNT_TOP:   bus_rdata <= {15'h0000, captured_decimation_count[24]};
        OFF_COARSE_HIGH: bus_rdata <= {8'h00, coarse_stage[COARSE_W-1:3]};
        OFF_COARSE_LOW:  bus_rdata <= {8'h00, coarse_stage[2:0], 5'h00};
        OFF_FINE_BYTE3:  bus_rdata <= {8'h00, fine_stage[28:21]};
        OFF_FINE_BYTE2:  bus_rdata <= {8'h00, fine_stage[20:13]};
        OFF_FINE_BYTE1:  bus_rdata <= {8'h00, fine_stage[12:5]};
        OFF_FINE_BYTE0:  bus_rdata <= {8'h00, fine_stage[4:0], 3'h0};
        default:         bus_rdata <= 16'h0000;
      endcase
    end
  end

  property p_clear_pulse;
    @(posedge clk_sys) disable iff (rst)
      wr_hit_clear && !$past(wr_hit_clear) |-> ##2 filter_clear;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("clear write gave no pulse");

  property p_clear_single;
    @(posedge clk_sys) disable iff (rst) filter_clear |=> !filter_clear;
  endproperty
  a_clear_single: assert property (p_clear_single) else $error("clear pulse too long");

  property p_counter_kept;
    @(posedge clk_sys) disable iff (rst)
      filter_clear && !sample_valid |=> $stable(decim_counter);
  endproperty
  a_counter_kept: assert property (p_counter_kept) else $error("clear moved counter");

  property p_capture;
    @(posedge clk_sys) disable iff (rst)
      capture_pulse && !trig_rise |=> captured_decimation_count == $past(decim_counter);
  endproperty
  a_capture: assert property (p_capture) else $error("capture wrong");

  property p_hold;
    @(posedge clk_sys) disable iff (rst)
      !capture_pulse && !trig_rise |=> $stable(captured_decimation_count);
  endproperty
  a_hold: assert property (p_hold) else $error("captured count moved");

  property p_accum;
    @(posedge clk_sys) disable iff (rst)
      sample_valid && !xfer_req |=> work_phase == $past(work_phase) + $past(work_freq);
  endproperty
  a_accum: assert property (p_accum) else $error("phase not advanced");

  property p_bypass;
    @(posedge clk_sys) disable iff (rst) decimation_bypass == (stage_select == 5'h00);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass mismatch");

  property p_mode_reset;
    @(posedge clk_sys) disable iff (rst) converter_reset == (converter_mode_select == MODE_RESET);
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("converter reset mismatch");

  property p_recall;
    @(posedge clk_sys) disable iff (rst)
      xfer_req && xfer_opcode == 4'h6 |=> work_freq == {$past(coarse_stage), $past(fine_stage)};
  endproperty
  a_recall: assert property (p_recall) else $error("recall failed");

  property p_recall_phase;
    @(posedge clk_sys) disable iff (rst)
      xfer_req && xfer_opcode == 4'h7 |=> work_phase == {$past(coarse_stage), $past(fine_stage)};
  endproperty
  a_recall_phase: assert property (p_recall_phase) else $error("phase recall failed");

  property p_store_coarse_only;
    @(posedge clk_sys) disable iff (rst)
      xfer_req && xfer_opcode == 4'h8 |=> $stable(fine_stage);
  endproperty
  a_store_coarse_only: assert property (p_store_coarse_only) else $error("coarse store moved fine stage");

  property p_store_phase;
    @(posedge clk_sys) disable iff (rst)
      xfer_req && xfer_opcode == 4'hf |=> coarse_stage == $past(work_phase[ACC_W-1 -: COARSE_W]) &&
                                            fine_stage == $past(work_phase[FINE_W-1:0]);
  endproperty
  a_store_phase: assert property (p_store_phase) else $error("phase store failed");

  property p_nop_xfer;
    @(posedge clk_sys) disable iff (rst)
      xfer_req && xfer_opcode == OPC_NOP && !sample_valid |=>
        $stable(work_freq) && $stable(work_phase) && $stable(coarse_stage) && $stable(fine_stage);
  endproperty
  a_nop_xfer: assert property (p_nop_xfer) else $error("no-op transfer changed a register");

  property p_trig_shift;
    @(posedge clk_sys) disable iff (rst) trig_rise |=> trigger_shift == $past(trigger_shift_in);
  endproperty
  a_trig_shift: assert property (p_trig_shift) else $error("trigger shift not captured");
endmodule

// ===== sim/zdc_top_tb.sv
// testbench: register-level checks of the zoom/decimation control block
module zdc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import zdc_pkg::*;
  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic [5:0]         bus_addr = 6'h00;
  logic [15:0]        bus_wdata = 16'h0000;
  logic               bus_wr = 1'b0;
  logic               bus_rd = 1'b0;
  logic [15:0]        bus_rdata;
  logic               sample_valid = 1'b0;
  logic signed [15:0] sample_in = 16'sh1000;
  logic               trigger_event = 1'b0;
  logic [1:0]         trigger_shift_in = 2'h0;
  logic [2:0]         converter_mode_select;
  logic               converter_reset;
  logic [4:0]         stage_select;
  logic               decimation_bypass;
  logic [4:0]         trigger_bw_exponent;
  logic               filter_clear;
  logic [COUNT_W-1:0] decim_counter;
  logic               shifted_valid;
  logic signed [15:0] shifted_re;
  logic signed [15:0] shifted_im;
  int                 mismatches = 0;
  int                 num_checks = 0;
  int                 clr_cnt = 0;
  int                 sv_cnt = 0;
  logic [5:0]         sa [6] = '{OFF_COARSE_HIGH, OFF_COARSE_LOW, OFF_FINE_BYTE3, OFF_FINE_BYTE2,
                                 OFF_FINE_BYTE1, OFF_FINE_BYTE0};

  zdc_top i_zdc_top (
    .clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .sample_valid(sample_valid), .sample_in(sample_in),
    .trigger_event(trigger_event), .trigger_shift_in(trigger_shift_in),
    .converter_mode_select(converter_mode_select), .converter_reset(converter_reset),
    .stage_select(stage_select), .decimation_bypass(decimation_bypass),
    .trigger_bw_exponent(trigger_bw_exponent), .filter_clear(filter_clear),
    .decim_counter(decim_counter), .shifted_valid(shifted_valid), .shifted_re(shifted_re),
    .shifted_im(shifted_im)
  );

  always #4 clk_sys = ~clk_sys;

  // pulse counters: a stuck-high strobe shows up as an extra count
  always @(posedge clk_sys) begin
    if (filter_clear === 1'b1) clr_cnt++;
    if (shifted_valid === 1'b1) sv_cnt++;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // held several cycles only to see that strobes still pulse once
  task automatic wr(input logic [5:0] a, input logic [15:0] d, input int hold = 1);
    @(posedge clk_sys);
    #1 bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    repeat (hold) @(posedge clk_sys);
    #1 bus_wr = 1'b0;
  endtask

  task automatic rchk(input logic [5:0] a, input logic [15:0] exp, input logic [15:0] m = 16'hffff);
    @(posedge clk_sys);
    #1 bus_addr = a;
    bus_rd = 1'b1;
    @(posedge clk_sys);
    #1 bus_rd = 1'b0;
    tick(1);
    chk($sformatf("read %h", a), {16'h0, exp & m}, {16'h0, bus_rdata & m});
  endtask

  task automatic samples(input int n);
    @(posedge clk_sys);
    #1 sample_valid = 1'b1;
    repeat (n) @(posedge clk_sys);
    #1 sample_valid = 1'b0;
  endtask

  task automatic xfer(input logic [15:0] op);
    wr(OFF_ZOOM_CTRL, op);
    wr(OFF_LO_XFER, 16'h0000);
  endtask

  // staging bytes in order coarse high, coarse low, fine 3..0; upper bus byte set to catch leaks
  task automatic ld(input logic [47:0] v);
    for (int i = 0; i < 6; i++) wr(sa[i], {8'hff, v[47-8*i -: 8]});
  endtask

  task automatic rd_all(input logic [47:0] v);
    for (int i = 0; i < 6; i++) rchk(sa[i], {8'h00, v[47-8*i -: 8]});
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    mismatches++;
    $display("Error run time expected finish seen hang");
    results();
  end

  initial begin
    int n0;
    repeat (16) @(posedge clk_sys);
    #1 rst = 1'b0;
    chk("converter_reset", 1, converter_reset);
    chk("decimation_bypass", 1, decimation_bypass);
    chk("bus_rdata", 0, bus_rdata);
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      wr(OFF_CONV_CTRL, 16'(m << 5));
      tick(1);
      chk("converter_mode_select", m, converter_mode_select);
      chk("converter_reset", m == 0, converter_reset);
    end
    $display("test converter mode done");
    for (int n = 0; n < 25; n++) begin
      wr(OFF_COUNT_LOW, 16'hffe0 | 16'(n));
      tick(1);
      chk("stage_select", n, stage_select);
      chk("decimation_bypass", n == 0, decimation_bypass);
      if (n > 0) chk("trigger_bw_exponent", n + 1, trigger_bw_exponent);
    end
    $display("test stage select done");
    wr(OFF_COUNT_LOW, 16'h0003);
    samples(301);
    tick(2);
    chk("decim_counter", 301, decim_counter);
    // phase still zero here: cosine is full scale, sine is zero
    chk("shifted_re near", 1, shifted_re > 16'sh0ff0 && shifted_re <= 16'sh1000);
    chk("shifted_im", 0, shifted_im);
    trigger_shift_in = 2'h2;
    trigger_event = 1'b1;
    tick(4);
    trigger_event = 1'b0;
    rchk(OFF_COUNT_LOW, 16'h062d);
    samples(5);
    rchk(OFF_COUNT_LOW, 16'h062d);
    wr(OFF_COUNT_BYTE2, 16'h5a5a, 3);
    tick(3);
    rchk(OFF_COUNT_LOW, 16'h0032, 16'h04ff);
    rchk(OFF_COUNT_BYTE1, 16'h0001);
    rchk(OFF_COUNT_BYTE2, 16'h0000);
    rchk(OFF_COUNT_TOP, 16'h0000);
    rchk(6'h00, 16'h0000);
    $display("test capture done");
    n0 = clr_cnt;
    wr(OFF_COUNT_BYTE1, 16'hffff, 3);
    tick(6);
    chk("filter_clear pulses", n0 + 1, clr_cnt);
    chk("decim_counter", 306, decim_counter);
    $display("test filter clear done");
    ld(48'h5aff_a53c_81ff);
    rd_all(48'h5ae0_a53c_81f8);
    $display("test staging done");
    ld(48'h0020_0000_0000);
    wr(OFF_ZOOM_CTRL, 16'h0006);
    wr(OFF_LO_XFER, 16'h0000);
    ld(48'h0000_1234_5678);
    wr(OFF_ZOOM_CTRL, 16'h0007);
    wr(OFF_LO_XFER, 16'h0000);
    n0 = sv_cnt;
    samples(3);
    tick(6);
    chk("shifted_valid pulses", n0 + 3, sv_cnt);
    ld(48'h0);
    wr(OFF_ZOOM_CTRL, 16'h0000);
    wr(OFF_LO_XFER, 16'h0000);
    rd_all(48'h0);
    wr(OFF_ZOOM_CTRL, 16'h000f);
    wr(OFF_LO_XFER, 16'h0000);
    rd_all(48'h0060_1234_5678);
    wr(OFF_ZOOM_CTRL, 16'h000e);
    wr(OFF_LO_XFER, 16'hffff);
    rd_all(48'h0020_0000_0000);
    ld(48'hffff_ffff_ffff);
    xfer(16'h0008);
    rd_all(48'h0020_ffff_fff8);
    xfer(16'h0004);
    ld(48'h0540_0000_0000);
    xfer(16'h0002);
    xfer(16'h000e);
    rd_all(48'h0540_ffff_fff8);
    xfer(16'h0005);
    xfer(16'h0003);
    ld(48'h0);
    xfer(16'h000b);
    rd_all(48'h0540_0000_0000);
    xfer(16'h000d);
    rd_all(48'h0540_ffff_fff8);
    ld(48'h0);
    xfer(16'h000c);
    rd_all(48'h0000_ffff_fff8);
    xfer(16'h000a);
    rd_all(48'h0540_ffff_fff8);
    $display("test transfer done");
    // quarter turn of phase: cosine is zero, sine is full scale
    ld(48'h4000_0000_0000);
    xfer(16'h0007);
    samples(1);
    tick(2);
    chk("shifted_re", 0, shifted_re);
    chk("shifted_im near", 1, shifted_im > 16'sh0ff0 && shifted_im <= 16'sh1000);
    $display("test shifter done");
    results();
  end
endmodule
